// ### design/sgpc_top.sv
// global power configuration register slice with ahb-lite slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module sgpc_top #(
  parameter int STEP_CYCLES = sgpc_pkg::SGPC_STEP_CYCLES
) (
  input wire logic ref_clk, // system clock 10 mhz
  input wire logic reset_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire sgpc_pkg::sgpc_egress_t egress, // frame egress info
  input wire logic energy_detect, // energy seen on the line
  output logic insert_tail_byte, // add byte before fcs now
  output logic drop_pause_frame, // discard this pause frame
  output sgpc_pkg::sgpc_ctrl_t ctrl // steering enables and power controls
);
  logic tail_reg, tail_next;
  logic pass_reg, pass_next;
  logic pll_reg, pll_next;
  logic [1:0] mode_reg, mode_next;
  logic [7:0] dwell_reg, dwell_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] widx_reg, widx_next;
  logic [31:0] presc_reg, presc_next;
  logic [7:0] steps_reg, steps_next;
  sgpc_pkg::sgpc_sleep_t sleep_reg, sleep_next;
  logic accept;
  logic [7:0] aidx;
  logic energy_mode;
  logic tick;

  assign accept = hsel && hready && htrans[1];
  assign aidx = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign energy_mode = (mode_reg == sgpc_pkg::SGPC_ENERGY_SENSE_STATE);
  assign tick = (presc_reg == STEP_CYCLES - 1);

  // register file: writes land in the data phase, reads sample at address
  always_comb begin
    tail_next = tail_reg;
    pass_next = pass_reg;
    pll_next = pll_reg;
    mode_next = mode_reg;
    dwell_next = dwell_reg;
    rdata_next = rdata_reg;
    wr_pend_next = 1'b0;
    widx_next = widx_reg;
    if (wr_pend_reg) begin
      case (widx_reg)
        sgpc_pkg::SGPC_IDX_TAIL_PAUSE: begin
          tail_next = hwdata[sgpc_pkg::SGPC_TAIL_BIT];
          pass_next = hwdata[sgpc_pkg::SGPC_PASS_BIT];
        end
        sgpc_pkg::SGPC_IDX_POWER_MODE: begin
          pll_next = hwdata[sgpc_pkg::SGPC_PLL_BIT];
          mode_next = hwdata[sgpc_pkg::SGPC_MODE_LSB +: 2];
        end
        sgpc_pkg::SGPC_IDX_DWELL: begin
          dwell_next = hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (accept) begin
      wr_pend_next = hwrite;
      widx_next = aidx;
      rdata_next = 32'h0000_0000;
      if (!hwrite) begin
        case (aidx)
          sgpc_pkg::SGPC_IDX_TAIL_PAUSE: begin
            rdata_next[7:0] = sgpc_pkg::SGPC_TAIL_RSVD_VAL
              | {6'h00, tail_reg, pass_reg};
          end
          sgpc_pkg::SGPC_IDX_FACTORY_B: begin
            rdata_next[7:0] = sgpc_pkg::SGPC_FACTORY_RESET;
          end
          sgpc_pkg::SGPC_IDX_POWER_MODE: begin
            rdata_next[7:0] = {2'h0, pll_reg, mode_reg, 3'h0};
            // a write landing in this same cycle wins over the clear
            if (!(wr_pend_reg
              && (widx_reg == sgpc_pkg::SGPC_IDX_POWER_MODE))) begin
              mode_next = sgpc_pkg::SGPC_FULL_OPERATION_STATE;
            end
          end
          sgpc_pkg::SGPC_IDX_DWELL: begin
            rdata_next[7:0] = dwell_reg;
          end
          sgpc_pkg::SGPC_IDX_STATUS: begin
            rdata_next[7:0] = {5'h00, ctrl.pll_down, ctrl.low_power,
              ctrl.soft_down};
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tail_reg <= 1'b0;
      pass_reg <= 1'b0;
      pll_reg <= 1'b0;
      mode_reg <= sgpc_pkg::SGPC_FULL_OPERATION_STATE;
      dwell_reg <= sgpc_pkg::SGPC_DWELL_RESET;
      rdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      widx_reg <= 8'h00;
    end else begin
      tail_reg <= tail_next;
      pass_reg <= pass_next;
      pll_reg <= pll_next;
      mode_reg <= mode_next;
      dwell_reg <= dwell_next;
      rdata_reg <= rdata_next;
      wr_pend_reg <= wr_pend_next;
      widx_reg <= widx_next;
    end
  end

  // dwell timer: prescaler ticks every step, steps counted to dwell value
  always_comb begin
    presc_next = presc_reg;
    steps_next = steps_reg;
    sleep_next = sleep_reg;
    if (!energy_mode || energy_detect) begin
      presc_next = 32'h0000_0000;
      steps_next = 8'h00;
      sleep_next = sgpc_pkg::SGPC_AWAKE;
    end else begin
      case (sleep_reg)
        sgpc_pkg::SGPC_AWAKE: begin
          sleep_next = sgpc_pkg::SGPC_COUNTING;
        end
        sgpc_pkg::SGPC_COUNTING: begin
          if (steps_reg >= dwell_reg) begin
            sleep_next = sgpc_pkg::SGPC_ASLEEP;
          end else if (tick) begin
            presc_next = 32'h0000_0000;
            steps_next = steps_reg + 8'h01;
          end else begin
            presc_next = presc_reg + 32'h0000_0001;
          end
        end
        sgpc_pkg::SGPC_ASLEEP: begin
        end
        default: begin
          sleep_next = sgpc_pkg::SGPC_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_reg <= 32'h0000_0000;
      steps_reg <= 8'h00;
      sleep_reg <= sgpc_pkg::SGPC_AWAKE;
    end else begin
      presc_reg <= presc_next;
      steps_reg <= steps_next;
      sleep_reg <= sleep_next;
    end
  end

  always_comb begin
    ctrl.tail_tag_en = tail_reg;
    ctrl.pass_pause = pass_reg;
    ctrl.low_power = (sleep_reg == sgpc_pkg::SGPC_ASLEEP);
    ctrl.pll_down = pll_reg && energy_mode && ctrl.low_power;
    ctrl.soft_down = (mode_reg == sgpc_pkg::SGPC_SOFT_SHUTDOWN_STATE);
  end

  // egress steering: tag only on port five, filter pause unless passed
  assign insert_tail_byte = tail_reg && egress.fcs_start
    && (egress.port == 3'(sgpc_pkg::SGPC_PORT_TAG));
  assign drop_pause_frame = egress.is_pause && !pass_reg;
endmodule : sgpc_top

// ### include/sgpc_pkg.sv
// package for the global power configuration register slice
package sgpc_pkg;
  // register offsets are indices; byte address is four times the index
  localparam logic [7:0] SGPC_IDX_TAIL_PAUSE = 8'h0c;
  localparam logic [7:0] SGPC_IDX_FACTORY_B = 8'h0d;
  localparam logic [7:0] SGPC_IDX_POWER_MODE = 8'h0e;
  localparam logic [7:0] SGPC_IDX_DWELL = 8'h0f;
  localparam logic [7:0] SGPC_IDX_STATUS = 8'h10;
  // tail/pause register fields and reserved bit values
  localparam int SGPC_TAIL_BIT = 1;
  localparam int SGPC_PASS_BIT = 0;
  localparam logic [7:0] SGPC_TAIL_RSVD_VAL = 8'h44;
  // power mode register fields
  localparam int SGPC_PLL_BIT = 5;
  localparam int SGPC_MODE_LSB = 3;
  // reset values
  localparam logic [7:0] SGPC_DWELL_RESET = 8'h50;
  localparam logic [7:0] SGPC_FACTORY_RESET = 8'h00;
  // timing: dwell step 20 ms at a 100 ns clock
  localparam int SGPC_STEP_MS = 20;
  localparam int SGPC_CLK_NS = 100;
  localparam int SGPC_STEP_CYCLES = SGPC_STEP_MS * 1000000 / SGPC_CLK_NS;
  localparam int SGPC_PORT_TAG = 5;

  typedef enum logic [1:0] {
    SGPC_FULL_OPERATION_STATE = 2'b00,
    SGPC_ENERGY_SENSE_STATE = 2'b01,
    SGPC_SOFT_SHUTDOWN_STATE = 2'b10,
    SGPC_MODE_RESERVED = 2'b11
  } sgpc_mode_t;

  typedef enum logic [1:0] {
    SGPC_AWAKE = 2'b00,
    SGPC_COUNTING = 2'b01,
    SGPC_ASLEEP = 2'b11
  } sgpc_sleep_t;

  typedef struct packed {
    logic tail_tag_en;
    logic pass_pause;
    logic pll_down;
    logic low_power;
    logic soft_down;
  } sgpc_ctrl_t;

  typedef struct packed {
    logic [2:0] port;
    logic fcs_start;
    logic is_pause;
  } sgpc_egress_t;
endpackage : sgpc_pkg

// ### verification/sgpc_top_assertions.sv
// checker for the global power configuration slice
`timescale 1ns/1ps
module sgpc_top_assertions (
  input wire logic ref_clk, // clock
  input wire logic reset_n, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [31:0] hrdata, // data
  input wire logic hreadyout, // ready
  input wire logic hresp, // response
  input wire sgpc_pkg::sgpc_egress_t egress, // egress
  input wire logic energy_detect, // energy
  input wire logic insert_tail_byte, // tail
  input wire logic drop_pause_frame, // drop
  input wire sgpc_pkg::sgpc_ctrl_t ctrl // controls
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_tail;
    hsel && htrans[1] && !hwrite && haddr == 32'h30;
  endsequence
  a_tail_port_five: assert property (
    insert_tail_byte |-> egress.port == 3'h5) else $error("tail off port");
  a_tail_when_on: assert property (
    ctrl.tail_tag_en && egress.fcs_start && egress.port == 3'h5
    |-> insert_tail_byte) else $error("tail missing");
  a_pause_drop: assert property (
    drop_pause_frame == (egress.is_pause && !ctrl.pass_pause))
    else $error("pause drop wrong");
  a_pll_gated: assert property (
    ctrl.pll_down |-> ctrl.low_power) else $error("pll down early");
  a_energy_wakes: assert property (
    energy_detect [*3] |-> !ctrl.low_power) else $error("no wake");
  a_sleep_quiet: assert property (
    $rose(ctrl.low_power) |-> !$past(energy_detect))
    else $error("sleep with energy");
  a_bus_okay: assert property (
    hreadyout && !hresp) else $error("bus not ready");
  a_rsvd_read: assert property (
    s_rd_tail |=> hrdata[7:2] == 6'h11 && hrdata[31:8] == 24'h0)
    else $error("reserved bits wrong");
endmodule : sgpc_top_assertions
bind sgpc_top sgpc_top_assertions i_chk (.ref_clk, .reset_n, .hsel,
  .haddr, .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .egress,
  .energy_detect, .insert_tail_byte, .drop_pause_frame, .ctrl);

// ### verification/switch_global_power_config_test.sv
// self-checking bench for the global power configuration slice
`timescale 1ns/1ps
module switch_global_power_config_test;
  localparam int STEP = 4;
  logic ref_clk, reset_n, hsel, hwrite, energy_detect;
  logic insert_tail_byte, drop_pause_frame, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] v, d;
  sgpc_pkg::sgpc_egress_t egress, e;
  sgpc_pkg::sgpc_ctrl_t ctrl;
  int err_total, check_count, n;
  sgpc_top #(.STEP_CYCLES(STEP)) i_sgpc_top (.ref_clk, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .egress, .energy_detect, .insert_tail_byte,
    .drop_pause_frame, .ctrl);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic tail_exp(logic en, sgpc_pkg::sgpc_egress_t x);
    return en & x.fcs_start & (x.port == 3'h5);
  endfunction : tail_exp
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_total++;
        end_of_test;
      end
      @(posedge ref_clk);
    end
  endtask : edge_rdy
  task automatic xfer(logic wr, logic [7:0] idx, logic [31:0] wd);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    edge_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_rdy;
    r = hrdata;
  endtask : xfer
  task automatic sleep_wait;
    n = 0;
    while (ctrl.low_power !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      end_of_test;
    end
  endtask : sleep_wait
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, egress} = '0;
    hsize = 3'h2;
    hsel = 1'b1;
    energy_detect = 1'b1;
    reset_n = 1'b0;
    err_total = 0;
    check_count = 0;
    void'($urandom(73469));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    xfer(0, 8'h0c, 0);
    chk("tail_pause", r, 32'h44);
    xfer(0, 8'h0e, 0);
    chk("power_mode", r, 32'h0);
    xfer(0, 8'h0f, 0);
    chk("dwell", r, 32'h50);
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? 8'(i) : 8'($urandom) & 8'h03;
      e = (i < 4) ? 5'h16 | 5'(i & 1) : 5'($urandom);
      xfer(1, 8'h0c, {24'h0, v});
      egress <= e;
      @(posedge ref_clk);
      chk("insert_tail_byte", insert_tail_byte, tail_exp(v[1], e));
      chk("drop_pause_frame", drop_pause_frame, e.is_pause & ~v[0]);
    end
    for (int m = 0; m < 4; m++) begin
      xfer(1, 8'h0e, 32'h20 | (m << 3));
      #1;
      chk("soft_down", ctrl.soft_down, 32'(m == 2));
      xfer(0, 8'h0e, 0);
      chk("power_mode", r, 32'h20 | (m << 3));
      xfer(0, 8'h0e, 0);
      chk("power_mode", r, 32'h20);
    end
    d = 8'($urandom_range(3, 1));
    xfer(1, 8'h0f, {24'h0, d});
    energy_detect <= 1'b0;
    xfer(1, 8'h0e, 32'h28);
    repeat (d * STEP - 2) @(posedge ref_clk);
    energy_detect <= 1'b1;
    @(posedge ref_clk);
    energy_detect <= 1'b0;
    sleep_wait;
    chk("dwell_cycles", n >= d * STEP && n <= d * STEP + 4, 1);
    chk("pll_down", ctrl.pll_down, 1);
    xfer(0, 8'h10, 0);
    chk("status", r, 32'h6);
    xfer(1, 8'h0e, 32'h20);
    repeat (2) @(posedge ref_clk);
    chk("low_power", ctrl.low_power, 0);
    chk("pll_down", ctrl.pll_down, 0);
    end_of_test;
  end
endmodule : switch_global_power_config_test
